/* verilog/sic_pkg.sv */
`default_nettype none
package sic_pkg;
    // register byte offsets on the register bus
    localparam logic [7:0]  OFS_SPACE_BASE    = 8'h00;  // eight space words, 0x00 to 0x1C
    localparam logic [7:0]  OFS_SPACE_LAST    = 8'h1C;
    localparam logic [7:0]  OFS_COMMON_CTRL   = 8'h20;
    localparam logic [7:0]  OFS_STATUS        = 8'h24;
    // space bus control word layout
    localparam logic [31:0] SPACE_CTL_RESET   = 32'h36DB0600;
    localparam logic [31:0] SPACE_CTL_WMASK   = 32'h7FFFFFFF;  // bit 31 reserved
    localparam int          POS_IDLE_WRITE    = 28;            // idle_after_write, 30..28
    localparam int          POS_IDLE_RW_OTHER = 25;            // idle_read_write_other_space
    localparam int          POS_IDLE_RW_SAME  = 22;            // idle_read_write_same_space
    localparam int          IDLE_FIELD_W      = 3;
    // common control and status layout
    localparam int          POS_FLOAT_CTRL    = 0;             // strobe_float_control
    localparam logic        FLOAT_CTRL_RESET  = 1'b0;
    localparam int          POS_ST_BUSY       = 0;
    localparam int          POS_ST_PREV_VALID = 1;
    localparam int          POS_ST_PREV_WRITE = 2;
    localparam int          POS_ST_PREV_SPACE = 4;
    localparam int          POS_ST_COUNT      = 8;
    // space index: 0,1,2,3,4,5,6,7 stand for spaces 0,2,3,4,5A,5B,6A,6B
    localparam int          NUM_SPACES        = 8;
    localparam int          SPACE_W           = 3;
    localparam int          COUNT_W           = 4;
    // idle sequencer states
    typedef enum logic [1:0]
    {
        SEQ_READY  = 2'b00,
        SEQ_WAIT   = 2'b01,
        SEQ_SETTLE = 2'b10,
        SEQ_GO     = 2'b11
    } sic_seq_t;
    // idle field code to idle cycle count
    function automatic logic [COUNT_W-1:0] idle_decode(input logic [IDLE_FIELD_W-1:0] code);
        logic [COUNT_W-1:0] n;
        n = 4'h0;
        unique case (code)
            3'h0: n = 4'h0;
            3'h1: n = 4'h1;
            3'h2: n = 4'h2;
            3'h3: n = 4'h4;
            3'h4: n = 4'h6;
            3'h5: n = 4'h8;
            3'h6: n = 4'hA;
            3'h7: n = 4'hC;  // R10
        endcase
        return n;
    endfunction
endpackage
`default_nettype wire

/* verilog/sic_space_regs.sv */
`timescale 1ns/100ps
`default_nettype none
// eight space words with one write port and two registered read ports
module sic_space_regs
    import sic_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 we,
    input  wire logic [SPACE_W-1:0]   waddr,
    input  wire logic [31:0]          wdata,
    input  wire logic [SPACE_W-1:0]   raddr_a,
    output logic      [31:0]          rdata_a,
    input  wire logic [SPACE_W-1:0]   raddr_b,
    output logic      [31:0]          rdata_b
);
    logic [NUM_SPACES-1:0][31:0] words_reg;   // one word per space
    logic                        written_reg; // helper: any write seen since reset

    // storage: power-on reset only, no other clear exists
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            words_reg <= {NUM_SPACES{SPACE_CTL_RESET}};  // R3
        else if (we)
            words_reg[waddr] <= wdata & SPACE_CTL_WMASK;  // R6
    end

    // registered read ports, one for software, one for the sequencer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_a <= 32'h00000000;
            rdata_b <= 32'h00000000;
        end
        else
        begin
            rdata_a <= words_reg[raddr_a];
            rdata_b <= words_reg[raddr_b];
        end
    end

    // helper for the reset value check
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            written_reg <= 1'b0;
        else if (we)
            written_reg <= 1'b1;
    end

    property p_reset_value;
        @(posedge clk) disable iff (!rst_b) !written_reg |-> words_reg[0] == SPACE_CTL_RESET;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("space word lost its reset value"); // R3
    property p_hold_without_write;
        @(posedge clk) disable iff (!rst_b) !we |=> words_reg == $past(words_reg);
    endproperty
    a_hold_without_write: assert property (p_hold_without_write) else $error("space word changed without write"); // R4
    property p_write_lands;
        @(posedge clk) disable iff (!rst_b) we |=> words_reg[$past(waddr)] == ($past(wdata) & SPACE_CTL_WMASK);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write did not land in its space word"); // R6
endmodule
`default_nettype wire

/* verilog/sic_idle_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] float strobes and clock when control 0
// [R2] keep driving them when control 1
// [R3] space word 32 bits, reset 36DB0600
// [R4] only power-on reset clears space words
// [R5] software sets words before external access
// [R6] one word per each of eight spaces
// [R7] bits 30-28: idle after a write
// [R8] bits 27-25: read then write, other space
// [R9] bits 24-22: read then write, same space
// [R10] codes map to 0,1,2,4,6,8,10,12 cycles
// [R11] bit 31 reads zero, written zero
// [R12] classify pair, hold bus idle that long
module sic_idle_ctrl
    import sic_pkg::*;
(
    input  wire logic               CLOCK,
    input  wire logic               RST_B,
    input  wire logic               MANUAL_RESET,
    // apb slave
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [7:0]         PADDR,
    input  wire logic [31:0]        PWDATA,
    output logic      [31:0]        PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    // access requests from the bus state machine
    input  wire logic               ACC_REQ,
    input  wire logic               ACC_WRITE,
    input  wire logic [SPACE_W-1:0] ACC_SPACE,
    output logic                    ACC_GRANT,
    output logic                    BUS_IDLE,
    // standby and bus release
    input  wire logic               STANDBY,
    input  wire logic               BUS_RELEASED,
    // strobe and clock sources, and their pins
    input  wire logic               SECONDARY_CLOCK_SRC,
    input  wire logic               ROW_STROBE_UPPER_SRC,
    input  wire logic               ROW_STROBE_LOWER_SRC,
    input  wire logic               COLUMN_STROBE_UPPER_SRC,
    input  wire logic               COLUMN_STROBE_LOWER_SRC,
    output logic                    SECONDARY_BUS_CLOCK_OUT,
    output logic                    ROW_STROBE_UPPER,
    output logic                    ROW_STROBE_LOWER,
    output logic                    COLUMN_STROBE_UPPER,
    output logic                    COLUMN_STROBE_LOWER,
    output logic                    PIN_OE_B
);
    // bus decode
    logic                   setup_phase;     // psel without penable
    logic                   access_phase;    // psel with penable
    logic                   hit_space;       // address in space word range
    logic                   hit_ctrl;        // common control word
    logic                   hit_status;      // status word
    logic                   unmapped;        // nothing answers here
    logic                   mem_we;          // space word write strobe
    logic                   mem_sel_reg;     // access phase reads a space word
    logic [31:0]            misc_rdata_reg;  // control or status read data
    logic [31:0]            mem_rdata_a;     // space word for software
    logic [31:0]            mem_rdata_b;     // previous space word for sequencer
    logic [31:0]            status_word;     // live status
    // common control
    logic                   float_ctrl_reg;  // strobe_float_control
    // sequencer
    sic_seq_t               seq_reg;
    sic_seq_t               seq_next;
    logic [COUNT_W-1:0]     cnt_reg;         // idle cycles left
    logic [COUNT_W-1:0]     cnt_next;
    logic                   prev_valid_reg;  // a previous access exists
    logic                   prev_write_reg;  // previous access direction
    logic [SPACE_W-1:0]     prev_space_reg;  // previous access space
    logic [COUNT_W-1:0]     need;            // idle cycles for this pair
    logic                   float_now;       // strobes go high impedance
    // helper logic for checks
    logic [COUNT_W-1:0]     need_hold_reg;
    logic [COUNT_W-1:0]     idle_len_reg;

    // pick the idle field that matches the access pair
    function automatic logic [COUNT_W-1:0] pair_idle(
        input logic                valid,
        input logic                pwr,
        input logic [SPACE_W-1:0]  psp,
        input logic                nwr,
        input logic [SPACE_W-1:0]  nsp,
        input logic [31:0]         word);
        logic [COUNT_W-1:0] n;
        n = 4'h0;
        if (!valid)
            n = 4'h0;  // first access after reset has nothing to follow
        else if (pwr)
            n = idle_decode(word[POS_IDLE_WRITE +: IDLE_FIELD_W]);  // R7
        else if (nwr && (psp != nsp))
            n = idle_decode(word[POS_IDLE_RW_OTHER +: IDLE_FIELD_W]);  // R8
        else if (nwr)
            n = idle_decode(word[POS_IDLE_RW_SAME +: IDLE_FIELD_W]);  // R9
        else
            n = 4'h0;  // read-read pairs get no idle cycles
        return n;
    endfunction

    // address decode, combinational
    always_comb
    begin
        setup_phase  = PSEL && !PENABLE;
        access_phase = PSEL && PENABLE;
        hit_space    = (PADDR[1:0] == 2'h0) && (PADDR <= OFS_SPACE_LAST);
        hit_ctrl     = (PADDR == OFS_COMMON_CTRL);
        hit_status   = (PADDR == OFS_STATUS);
        unmapped     = !(hit_space || hit_ctrl || hit_status);
        mem_we       = access_phase && PWRITE && hit_space;
    end

    // zero wait state slave; unmapped access answers with an error
    assign PREADY  = 1'b1;
    assign PSLVERR = access_phase && unmapped;

    sic_space_regs u_regs
    (
        .clk     (CLOCK),
        .rst_b   (RST_B),
        .we      (mem_we),
        .waddr   (PADDR[4:2]),
        .wdata   (PWDATA),
        .raddr_a (PADDR[4:2]),
        .rdata_a (mem_rdata_a),
        .raddr_b (prev_space_reg),
        .rdata_b (mem_rdata_b)
    );

    // live status word
    always_comb
    begin
        status_word                                    = 32'h00000000;
        status_word[POS_ST_BUSY]                       = (seq_reg == SEQ_WAIT);
        status_word[POS_ST_PREV_VALID]                 = prev_valid_reg;
        status_word[POS_ST_PREV_WRITE]                 = prev_write_reg;
        status_word[POS_ST_PREV_SPACE +: SPACE_W]      = prev_space_reg;
        status_word[POS_ST_COUNT +: COUNT_W]           = cnt_reg;
    end

    // read data captured in the setup cycle, shown in the access phase
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            mem_sel_reg    <= 1'b0;
            misc_rdata_reg <= 32'h00000000;
        end
        else if (setup_phase)
        begin
            mem_sel_reg <= hit_space;
            if (hit_ctrl)
                misc_rdata_reg <= {31'h00000000, float_ctrl_reg};
            else if (hit_status)
                misc_rdata_reg <= status_word;
            else
                misc_rdata_reg <= 32'h00000000;  // unmapped reads zero
        end
    end

    // bit 31 is never stored, so it reads zero
    assign PRDATA = mem_sel_reg ? (mem_rdata_a & SPACE_CTL_WMASK) : misc_rdata_reg;  // R11

    // common control, power-on reset only like the space words
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            float_ctrl_reg <= FLOAT_CTRL_RESET;
        else if (access_phase && PWRITE && hit_ctrl)
            float_ctrl_reg <= PWDATA[POS_FLOAT_CTRL];
    end

    // pin drive: float only in standby or release with control clear
    assign float_now = (STANDBY || BUS_RELEASED) && !float_ctrl_reg;  // R1 R2

    // pins leave from flops so the enable and levels move together
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            PIN_OE_B                <= 1'b0;
            SECONDARY_BUS_CLOCK_OUT <= 1'b0;
            ROW_STROBE_UPPER        <= 1'b1;
            ROW_STROBE_LOWER        <= 1'b1;
            COLUMN_STROBE_UPPER     <= 1'b1;
            COLUMN_STROBE_LOWER     <= 1'b1;
        end
        else
        begin
            PIN_OE_B                <= float_now;  // R1 R2
            SECONDARY_BUS_CLOCK_OUT <= SECONDARY_CLOCK_SRC;
            ROW_STROBE_UPPER        <= ROW_STROBE_UPPER_SRC;
            ROW_STROBE_LOWER        <= ROW_STROBE_LOWER_SRC;
            COLUMN_STROBE_UPPER     <= COLUMN_STROBE_UPPER_SRC;
            COLUMN_STROBE_LOWER     <= COLUMN_STROBE_LOWER_SRC;
        end
    end

    // idle count for the waiting request, from the previous space's word
    assign need = pair_idle(prev_valid_reg, prev_write_reg, prev_space_reg,
                            ACC_WRITE, ACC_SPACE, mem_rdata_b);  // R12

    // grant needs a held request; settle gives the read port one cycle
    assign ACC_GRANT = ACC_REQ && (((seq_reg == SEQ_READY) && (need == 4'h0)) || (seq_reg == SEQ_GO));  // R12
    assign BUS_IDLE  = (seq_reg == SEQ_WAIT);

    // sequencer next state
    always_comb
    begin
        seq_next = seq_reg;
        cnt_next = cnt_reg;
        unique case (seq_reg)
            SEQ_READY:
            begin
                if (ACC_REQ && (need == 4'h0))
                    seq_next = SEQ_SETTLE;
                else if (ACC_REQ)
                begin
                    seq_next = SEQ_WAIT;  // R12
                    cnt_next = need;
                end
            end
            SEQ_WAIT:
            begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1)
                    seq_next = SEQ_GO;
            end
            SEQ_GO:
            begin
                if (ACC_REQ)
                    seq_next = SEQ_SETTLE;
            end
            SEQ_SETTLE:
            begin
                seq_next = SEQ_READY;
            end
        endcase
    end

    // sequencer state; manual reset restarts it but spares the words
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            seq_reg <= SEQ_READY;
            cnt_reg <= 4'h0;
        end
        else if (MANUAL_RESET)
        begin
            seq_reg <= SEQ_READY;  // R4
            cnt_reg <= 4'h0;
        end
        else
        begin
            seq_reg <= seq_next;
            cnt_reg <= cnt_next;
        end
    end

    // previous access, recorded at each grant
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            prev_valid_reg <= 1'b0;
            prev_write_reg <= 1'b0;
            prev_space_reg <= 3'h0;
        end
        else if (MANUAL_RESET)
            prev_valid_reg <= 1'b0;
        else if (ACC_GRANT)
        begin
            prev_valid_reg <= 1'b1;  // R12
            prev_write_reg <= ACC_WRITE;
            prev_space_reg <= ACC_SPACE;
        end
    end

    // helper: loaded count and length of the idle run
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            need_hold_reg <= 4'h0;
            idle_len_reg  <= 4'h0;
        end
        else
        begin
            if ((seq_reg == SEQ_READY) && (seq_next == SEQ_WAIT))
                need_hold_reg <= need;
            idle_len_reg <= BUS_IDLE ? idle_len_reg + 4'h1 : 4'h0;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    property p_float_low;
        (STANDBY || BUS_RELEASED) && !float_ctrl_reg |=> PIN_OE_B;
    endproperty
    a_float_low: assert property (p_float_low) else $error("strobes driven with float control clear"); // R1
    property p_drive_high;
        float_ctrl_reg |=> !PIN_OE_B;
    endproperty
    a_drive_high: assert property (p_drive_high) else $error("strobes floated with float control set"); // R2
    property p_after_write;
        (seq_reg == SEQ_READY) && ACC_REQ && prev_valid_reg && prev_write_reg
            |-> need == idle_decode(mem_rdata_b[30:28]);
    endproperty
    a_after_write: assert property (p_after_write) else $error("idle after write picked wrong field"); // R7
    property p_rw_other;
        (seq_reg == SEQ_READY) && ACC_REQ && prev_valid_reg && !prev_write_reg && ACC_WRITE
            && (ACC_SPACE != prev_space_reg) |-> need == idle_decode(mem_rdata_b[27:25]);
    endproperty
    a_rw_other: assert property (p_rw_other) else $error("read-write other space picked wrong field"); // R8
    property p_rw_same;
        (seq_reg == SEQ_READY) && ACC_REQ && prev_valid_reg && !prev_write_reg && ACC_WRITE
            && (ACC_SPACE == prev_space_reg) |-> need == idle_decode(mem_rdata_b[24:22]);
    endproperty
    a_rw_same: assert property (p_rw_same) else $error("read-write same space picked wrong field"); // R9
    property p_decode_top;
        (seq_reg == SEQ_READY) && ACC_REQ && prev_valid_reg && prev_write_reg
            && (mem_rdata_b[30:28] == 3'h7) |-> need == 4'hC;
    endproperty
    a_decode_top: assert property (p_decode_top) else $error("code seven did not give twelve"); // R10
    property p_reserved_zero;
        PSEL && PENABLE && !PWRITE |-> !PRDATA[31];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one"); // R11
    property p_idle_length;
        $fell(BUS_IDLE) |-> ($past(idle_len_reg) + 4'h1) == need_hold_reg;
    endproperty
    a_idle_length: assert property (p_idle_length) else $error("idle run length differs from count"); // R12
    property p_no_grant_idle;
        BUS_IDLE |-> !ACC_GRANT;
    endproperty
    a_no_grant_idle: assert property (p_no_grant_idle) else $error("grant during idle cycles"); // R12

    c_idle_run: cover property ((seq_reg == SEQ_READY) && ACC_REQ && (need != 4'h0) ##1 BUS_IDLE[*2]);
    c_float: cover property (STANDBY && !float_ctrl_reg ##1 PIN_OE_B);
    c_bus_error: cover property (PSEL && PENABLE && unmapped);
endmodule
`default_nettype wire

/* tb/sic_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// far side: the access requester and the five pin wires
module sic_mem_model
    import sic_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               acc_grant,
    input  wire logic               bus_idle,
    input  wire logic [4:0]         pin_drv,
    input  wire logic               pin_oe_b,
    output logic                    acc_req,
    output logic                    acc_write,
    output logic      [SPACE_W-1:0] acc_space,
    output logic      [4:0]         pin_wire
);
    logic [4:0] last_drv;  // last level seen driven on the pins

    initial
    begin
        acc_req   = 1'b0;
        acc_write = 1'b0;
        acc_space = 3'h0;
    end

    // remember the driven level while the pins are enabled
    always_ff @(posedge clk)
    begin
        if (!pin_oe_b)
        begin
            last_drv <= pin_drv;
        end
    end

    // floated wire keeps no stale level, so show its inverse
    assign pin_wire = pin_oe_b ? ~last_drv : pin_drv;

    // one access: held until granted, inserted idle cycles counted
    task automatic access(input logic wr, input logic [SPACE_W-1:0] sp, output int idle);
        int n;
        @(posedge clk);
        acc_req   <= 1'b1;
        acc_write <= wr;
        acc_space <= sp;
        idle = 0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (bus_idle === 1'b1)
                idle++;
        end while (acc_grant !== 1'b1 && n < 100);
        // released direction no longer shows the old value
        acc_req   <= 1'b0;
        acc_write <= ~wr;
        if (acc_grant !== 1'b1)
            idle = -1;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("FAIL %0t mismatch got %0h exp %0h", $time, a, b); end end
module tb
    import sic_pkg::*;
;
    typedef struct {logic pw; logic [2:0] ps; logic nw; logic [2:0] ns; int exp;} sic_row_t;
    logic        clk = 1'b0, rst_b = 1'b0, manual = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        standby = 1'b0, released = 1'b0;
    logic [4:0]  src = 5'h0A;        // clock and strobe sources
    wire  [31:0] prdata;
    wire         pready, pslverr, acc_req, acc_write, acc_grant, bus_idle, pin_oe_b;
    wire  [2:0]  acc_space;
    wire  [4:0]  pins, pin_wire;     // pin outputs and resolved wires
    int          fail_count = 0;
    int          checks = 0;
    int          dec[8] = '{0, 1, 2, 4, 6, 8, 10, 12};
    // space 1: write 4, read-write other 1, same 2; space 2 all zero
    sic_row_t    rows[6] = '{'{1'h1, 3'h1, 1'h0, 3'h1, 4}, '{1'h1, 3'h1, 1'h1, 3'h2, 4},
                             '{1'h0, 3'h1, 1'h1, 3'h2, 1}, '{1'h0, 3'h1, 1'h1, 3'h1, 2},
                             '{1'h0, 3'h1, 1'h0, 3'h2, 0}, '{1'h1, 3'h2, 1'h1, 3'h1, 0}};

    always #50 clk = ~clk;

    sic_idle_ctrl DUT (.CLOCK(clk), .RST_B(rst_b), .MANUAL_RESET(manual), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ACC_REQ(acc_req), .ACC_WRITE(acc_write), .ACC_SPACE(acc_space), .ACC_GRANT(acc_grant),
        .BUS_IDLE(bus_idle), .STANDBY(standby), .BUS_RELEASED(released), .SECONDARY_CLOCK_SRC(src[4]),
        .ROW_STROBE_UPPER_SRC(src[3]), .ROW_STROBE_LOWER_SRC(src[2]), .COLUMN_STROBE_UPPER_SRC(src[1]),
        .COLUMN_STROBE_LOWER_SRC(src[0]), .SECONDARY_BUS_CLOCK_OUT(pins[4]), .ROW_STROBE_UPPER(pins[3]),
        .ROW_STROBE_LOWER(pins[2]), .COLUMN_STROBE_UPPER(pins[1]), .COLUMN_STROBE_LOWER(pins[0]),
        .PIN_OE_B(pin_oe_b));

    sic_mem_model mdl (.clk(clk), .acc_grant(acc_grant), .bus_idle(bus_idle), .pin_drv(pins),
        .pin_oe_b(pin_oe_b), .acc_req(acc_req), .acc_write(acc_write), .acc_space(acc_space),
        .pin_wire(pin_wire));

    // verdict and end of run
    task end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one apb transfer; an idle edge first so psel never toggles twice in a step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fail_count++;
            $display("FAIL %0t register bus timeout", $time);
            end_sim;
        end
    endtask

    // write, then let the sequencer see the new word
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        repeat (2) @(posedge clk);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    // access through the far side; a hang ends the run
    task acc(input logic w, input logic [2:0] sp, output int n);
        mdl.access(w, sp, n);
        if (n < 0)
        begin
            fail_count++;
            $display("FAIL %0t access grant timeout", $time);
            end_sim;
        end
    endtask

    initial
    begin
        logic [31:0] r;
        logic        e;
        int          n;
        int          i;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        // reset image of all eight words and float control
        for (i = 0; i < 8; i++)
        begin
            rd(8'(4 * i), r);
            `CHK(r, 32'h36DB0600)
        end
        rd(8'h20, r);
        `CHK(r[0], 1'b0)
        // spaces 1 and 2 set up before any access to them
        wr(8'h04, 32'h32800600);
        wr(8'h08, 32'h00000000);
        rd(8'h04, r);
        `CHK(r, 32'h32800600)
        rd(8'h0C, r);
        `CHK(r, 32'h36DB0600)
        // access pairs, count taken from the previous space's word
        for (i = 0; i < 6; i++)
        begin
            acc(rows[i].pw, rows[i].ps, n);
            acc(rows[i].nw, rows[i].ns, n);
            `CHK(n, rows[i].exp)
        end
        // every code of the write field, write-write in space 0
        for (i = 0; i < 8; i++)
        begin
            wr(8'h00, 32'(i) << 28);
            acc(1'b1, 3'h0, n);
            acc(1'b1, 3'h0, n);
            `CHK(n, dec[i])
        end
        // unmapped address refused
        apb(1'b0, 8'h40, 32'h0, r, e);
        `CHK(e, 1'b1)
        // manual reset keeps words, forgets the previous access
        manual <= 1'b1;
        @(posedge clk);
        manual <= 1'b0;
        rd(8'h04, r);
        `CHK(r, 32'h32800600)
        acc(1'b1, 3'h1, n);
        `CHK(n, 0)
        // status: previous access valid, a write, space index 1
        apb(1'b0, 8'h24, 32'h0, r, e);
        `CHK(r, 32'h00000016)
        `CHK(e, 1'b0)
        // control 0: pins float in standby and in bus release
        for (i = 0; i < 2; i++)
        begin
            standby <= (i == 0);
            released <= (i == 1);
            repeat (2) @(posedge clk);
            `CHK(pin_oe_b, 1'b1)
        end
        standby <= 1'b0;
        released <= 1'b0;
        // words survive standby
        rd(8'h04, r);
        `CHK(r, 32'h32800600)
        // control 1: pins keep driving the sources
        wr(8'h20, 32'h1);
        rd(8'h20, r);
        `CHK(r[0], 1'b1)
        released <= 1'b1;
        standby <= 1'b1;
        src <= 5'h15;
        repeat (2) @(posedge clk);
        `CHK(pin_oe_b, 1'b0)
        `CHK(pin_wire, 5'h15)
        released <= 1'b0;
        standby <= 1'b0;
        // second power-on reset restores the words
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h04, r);
        `CHK(r, 32'h36DB0600)
        rd(8'h20, r);
        `CHK(r[0], 1'b0)
        end_sim;
    end
endmodule
`undef CHK
`default_nettype wire
